// File: rbcd_pkg.sv
// constants, register map and types of the battery, century and defaults block
package rbcd_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [15:0] OFF_FLAGS    = 16'h1ff0;
    localparam logic [15:0] OFF_CTRL     = 16'h1ff4;
    localparam logic [15:0] OFF_WDOG     = 16'h1ff8;
    localparam logic [15:0] OFF_CLOCK    = 16'h1ffc;
    localparam logic [15:0] OFF_INT_STAT = 16'h1fe0;
    localparam logic [15:0] OFF_INT_MASK = 16'h1fe4;
    // ==========================================================
    // field positions
    localparam int FLAGS_BATT_LOW_POS = 4;
    localparam int FLAGS_ALARM_POS    = 6;
    localparam int CLOCK_CENT_EN_POS  = 5;
    localparam int CLOCK_CENT_BIT_POS = 4;
    localparam int INT_BATT_POS       = 0;
    localparam int INT_CENT_POS       = 1;
    localparam int INT_ALARM_POS      = 2;
    localparam int INT_WIDTH          = 3;
    localparam int SYNC_WIDTH         = 3;
    // ==========================================================
    // reset values
    localparam logic [7:0]           WDOG_RESET  = 8'h00;
    localparam logic [INT_WIDTH-1:0] INT_RESET   = 3'h0;
    localparam logic [31:0]          RDATA_RESET = 32'h0000_0000;

    // control bits, bit 0 upward: write hold, read hold, freq test, alarm en, backup alarm en
    typedef struct packed {
        logic alarm_in_backup_enable;
        logic alarm_flag_enable;
        logic frequency_test_enable;
        logic read_hold;
        logic write_hold;
    } rbcd_ctrl_t;

    typedef struct packed {
        logic       watchdog_steering;
        logic [4:0] watchdog_multiplier;
        logic [1:0] watchdog_resolution;
    } rbcd_wdog_t;

    localparam rbcd_ctrl_t CTRL_RESET = 5'h00;
endpackage

// File: rbcd_top.sv
// battery monitor, century bit and power-up defaults with an apb register slave

module rbcd_top
    import rbcd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        batt_low_pin,
    input  wire logic        supply_ok_pin,
    input  wire logic        osc_run_pin,
    input  wire logic        day_rollover,
    input  wire logic        century_rollover,
    input  wire logic        alarm_match,
    input  wire logic        power_down,
    output logic             alarm_irq_o,
    output logic             alarm_irq_oe_n,
    output logic             irq
);
    // ==========================================================
    // pin synchronisers
    // async levels: only the second stage is read by logic
    logic [SYNC_WIDTH-1:0] sync1_reg;
    logic [SYNC_WIDTH-1:0] sync2_reg;
    wire  [SYNC_WIDTH-1:0] pins_in = {osc_run_pin, supply_ok_pin, batt_low_pin};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pins_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    wire batt_low_s = sync2_reg[0];
    wire supply_ok  = sync2_reg[1];
    wire osc_run    = sync2_reg[2];

    // ==========================================================
    // apb decode
    wire setup     = psel & ~penable;
    wire access    = psel & penable;
    wire wr_acc    = access & pwrite;
    wire rd_acc    = access & ~pwrite;
    wire sel_flags = (paddr == OFF_FLAGS);
    wire sel_ctrl  = (paddr == OFF_CTRL);
    wire sel_wdog  = (paddr == OFF_WDOG);
    wire sel_clock = (paddr == OFF_CLOCK);
    wire sel_stat  = (paddr == OFF_INT_STAT);
    wire sel_mask  = (paddr == OFF_INT_MASK);
    wire hit       = sel_flags | sel_ctrl | sel_wdog | sel_clock | sel_stat | sel_mask;

    // one write strobe per writable register, from the access phase only; the read capture strobe comes from setup
    wire wr_ctrl   = wr_acc & sel_ctrl;
    wire wr_wdog   = wr_acc & sel_wdog;
    wire wr_clock  = wr_acc & sel_clock;
    wire wr_stat   = wr_acc & sel_stat;
    wire wr_mask   = wr_acc & sel_mask;
    wire rd_setup  = setup & ~pwrite;

    // every register answers in its single access cycle
    assign pready  = 1'b1;
    // raised in the access phase only, never during setup
    assign pslverr = access & ~hit;

    // ==========================================================
    // battery monitor
    logic bl_reg;
    logic bl_next;
    logic chk_pend_reg;
    logic chk_pend_next;

    // only monitored with main supply up and the oscillator running
    wire powered_run = supply_ok & osc_run;
    wire do_check    = (chk_pend_reg | day_rollover) & powered_run;
    wire batt_fail   = do_check & batt_low_s;

    // flags register is read-only, so no bus path reaches bl_reg
    assign bl_next       = do_check ? batt_low_s : bl_reg;
    assign chk_pend_next = chk_pend_reg & ~powered_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bl_reg <= 1'b0;
        end else begin
            bl_reg <= bl_next;
        end
    end

    // re-armed only by reset, which stands for power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chk_pend_reg <= 1'b1;
        end else begin
            chk_pend_reg <= chk_pend_next;
        end
    end

    // ==========================================================
    // alarm flag and its open-drain pin
    logic af_reg;
    logic af_next;
    wire  flags_rd = rd_acc & sel_flags;

    // a new match in the clearing cycle survives
    assign af_next = alarm_match | (af_reg & ~flags_rd);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            af_reg <= 1'b0;
        end else begin
            af_reg <= af_next;
        end
    end

    // ==========================================================
    // control and watchdog bits
    rbcd_ctrl_t ctrl_reg;
    rbcd_ctrl_t ctrl_next;
    rbcd_wdog_t wdog_reg;
    rbcd_wdog_t wdog_next;
    rbcd_ctrl_t ctrl_pd;

    // power-down keeps only the two alarm enables
    assign ctrl_pd = '{alarm_in_backup_enable: ctrl_reg.alarm_in_backup_enable,
                       alarm_flag_enable:      ctrl_reg.alarm_flag_enable,
                       default:                1'b0};

    // power-down wins over a write in the same cycle
    always_comb begin
        ctrl_next = ctrl_reg;
        if (power_down) begin
            ctrl_next = ctrl_pd;
        end else if (wr_ctrl) begin
            ctrl_next = rbcd_ctrl_t'(pwdata[4:0]);
        end
    end

    always_comb begin
        wdog_next = wdog_reg;
        if (power_down) begin
            wdog_next = rbcd_wdog_t'(WDOG_RESET);
        end else if (wr_wdog) begin
            wdog_next = rbcd_wdog_t'(pwdata[7:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_reg <= rbcd_wdog_t'(WDOG_RESET);
        end else begin
            wdog_reg <= wdog_next;
        end
    end

    // open-drain data fixed low; only the enable moves
    assign alarm_irq_o    = 1'b0;
    assign alarm_irq_oe_n = ~(af_reg & ctrl_reg.alarm_flag_enable);

    // ==========================================================
    // clock register: battery-backed, untouched by reset
    // no reset on purpose: contents start unknown on first power-up
    logic [7:0] clock_reg;
    logic [7:0] clock_next;
    logic [7:0] clock_wr;
    wire        clock_we = wr_clock;
    wire        cent_en  = clock_reg[CLOCK_CENT_EN_POS];
    wire        cent_tog = century_rollover & cent_en;

    // a rollover in a write cycle toggles the bit as written, or the kept old bit when write hold is clear
    always_comb begin
        clock_wr = clock_reg;
        if (clock_we) begin
            clock_wr = pwdata[7:0];
            if (!ctrl_reg.write_hold) begin
                clock_wr[CLOCK_CENT_BIT_POS] = clock_reg[CLOCK_CENT_BIT_POS];
            end
        end
        clock_next = clock_wr;
        if (cent_tog) begin
            clock_next[CLOCK_CENT_BIT_POS] = ~clock_wr[CLOCK_CENT_BIT_POS];
        end
    end

    always_ff @(posedge pclk) begin
        clock_reg <= clock_next;
    end

    // ==========================================================
    // interrupt status and mask
    logic [INT_WIDTH-1:0] stat_reg;
    logic [INT_WIDTH-1:0] stat_next;
    logic [INT_WIDTH-1:0] mask_reg;
    logic [INT_WIDTH-1:0] mask_next;
    wire  [INT_WIDTH-1:0] events = {alarm_match, cent_tog, batt_fail};
    wire  [INT_WIDTH-1:0] w1c    = wr_stat ? pwdata[INT_WIDTH-1:0] : INT_RESET;

    // one sticky bit per event; set wins over a clear in the same cycle
    generate
        for (gi = 0; gi < INT_WIDTH; gi++) begin : g_stat
            assign stat_next[gi] = events[gi] | (stat_reg[gi] & ~w1c[gi]);
        end
    endgenerate

    assign mask_next = wr_mask ? pwdata[INT_WIDTH-1:0] : mask_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= INT_RESET;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= INT_RESET;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // level output: stays up until the bit is cleared or masked off
    assign irq = |(stat_reg & mask_reg);

    // ==========================================================
    // read data, captured in the setup cycle
    logic [31:0] prdata_reg;
    logic [31:0] rd_mux;
    logic [7:0]  flags_val;

    always_comb begin
        flags_val = 8'h00;
        flags_val[FLAGS_BATT_LOW_POS] = bl_reg;
        flags_val[FLAGS_ALARM_POS]    = af_reg;
    end

    // capture before the access edge, so a clearing read still shows the old flag
    // holes read as zero
    always_comb begin
        rd_mux = RDATA_RESET;
        if (sel_flags) begin
            rd_mux = {24'h00_0000, flags_val};
        end else if (sel_ctrl) begin
            rd_mux = {27'h000_0000, ctrl_reg};
        end else if (sel_wdog) begin
            rd_mux = {24'h00_0000, wdog_reg};
        end else if (sel_clock) begin
            rd_mux = {24'h00_0000, clock_reg};
        end else if (sel_stat) begin
            rd_mux = {29'h000_0000, stat_reg};
        end else if (sel_mask) begin
            rd_mux = {29'h000_0000, mask_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= RDATA_RESET;
        end else if (rd_setup) begin
            prdata_reg <= rd_mux;
        end
    end

    assign prdata = prdata_reg;
endmodule // rbcd_top

// File: rbcd_chk.sv
// port assertions of the battery, century and defaults block
module rbcd_chk
    import rbcd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        alarm_match,
    input wire logic        alarm_irq_o,
    input wire logic        alarm_irq_oe_n,
    input wire logic        irq
);
    // ==========================================================
    // decode
    wire acc    = psel && penable;
    wire flg_rd = acc && !pwrite && paddr == OFF_FLAGS;
    wire ctl_wr = acc && pwrite && paddr == OFF_CTRL;
    wire mapped = paddr inside {OFF_FLAGS, OFF_CTRL, OFF_WDOG, OFF_CLOCK, OFF_INT_STAT,
                                OFF_INT_MASK};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence
    sequence s_alarm_held;
        !alarm_irq_oe_n && !flg_rd && !ctl_wr;
    endsequence
    // ==========================================================
    // assertions
    a_ready_high: assert property (pready) else $error("pready low");
    a_pin_low_only: assert property (!alarm_irq_o) else $error("irq data not low");
    a_reset_quiet: assert property (disable iff (1'b0) !presetn |=> !irq && alarm_irq_oe_n)
        else $error("outputs active in reset");
    a_read_clears: assert property (flg_rd && !alarm_match |=> alarm_irq_oe_n)
        else $error("flags read left alarm pin driven");
    a_alarm_sticky: assert property (s_alarm_held |=> !alarm_irq_oe_n)
        else $error("alarm pin released without flags read");
    a_upper_zero: assert property (s_rd_setup |=> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_bad_addr: assert property (acc && !mapped |-> pslverr) else $error("no error on hole");
    a_good_addr: assert property (acc && mapped |-> !pslverr) else $error("error on register");
    a_rdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data changed outside read setup");
endmodule // rbcd_chk

bind rbcd_top rbcd_chk rbcd_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarm_match(alarm_match), .alarm_irq_o(alarm_irq_o),
    .alarm_irq_oe_n(alarm_irq_oe_n), .irq(irq));

// File: rbcd_host.sv
// apb host that stands on the far side of the register bus
module rbcd_host (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [15:0] paddr,
    output logic      [31:0] pwdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
    end
    // request held until pready is seen, answer taken at that edge only
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // rbcd_host

// File: rbcd_top_tb_top.sv
// self-checking bench of the battery, century and defaults block
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, ex, got); end end
module rbcd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rbcd_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, batt = 1'b0, sup = 1'b0, osc = 1'b0;
    logic [3:0]  ev = 4'h0; // power_down, alarm_match, century_rollover, day_rollover
    logic        psel, penable, pwrite, pready, pslverr, irq_o, irq_oe_n, irq, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          errors = 0, n_tests = 0;
    always #25 pclk = ~pclk;
    rbcd_host rbcd_host_inst (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    rbcd_top rbcd_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .batt_low_pin(batt), .supply_ok_pin(sup), .osc_run_pin(osc),
        .day_rollover(ev[0]), .century_rollover(ev[1]), .alarm_match(ev[2]),
        .power_down(ev[3]), .alarm_irq_o(irq_o), .alarm_irq_oe_n(irq_oe_n), .irq(irq));
    // ==========================================================
    // tasks
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        rbcd_host_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] x, input string nm);
        rbcd_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
        `CHK(nm, x, q)
    endtask
    task automatic pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        @(posedge pclk);
        ev[i] <= 1'b0;
    endtask
    // pins pass a two-stage synchroniser, so give them time to land
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("mismatches %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        batt <= 1'b1;
        sup <= 1'b1;
        osc <= 1'b1;
        settle();
        rd(OFF_FLAGS, 32'h10, "bl_powerup");
        wr(OFF_FLAGS, 32'h00);
        rd(OFF_FLAGS, 32'h10, "bl_ro");
        batt <= 1'b0;
        osc <= 1'b0;
        settle();
        pulse(0);
        rd(OFF_FLAGS, 32'h10, "bl_no_osc");
        osc <= 1'b1;
        settle();
        pulse(0);
        rd(OFF_FLAGS, 32'h00, "bl_recheck");
        rd(OFF_INT_STAT, 32'h01, "int_stat");
        `CHK("irq_masked", 1'b0, irq)
        wr(OFF_INT_MASK, 32'h01);
        settle();
        `CHK("irq_on", 1'b1, irq)
        wr(OFF_INT_STAT, 32'h01);
        settle();
        `CHK("irq_cleared", 1'b0, irq)
        wr(OFF_CTRL, 32'h01);
        wr(OFF_CLOCK, 32'h30);
        rd(OFF_CLOCK, 32'h30, "cb_write");
        pulse(1);
        rd(OFF_CLOCK, 32'h20, "cb_toggle");
        wr(OFF_CTRL, 32'h00);
        wr(OFF_CLOCK, 32'h10);
        rd(OFF_CLOCK, 32'h00, "cb_locked");
        pulse(1);
        rd(OFF_CLOCK, 32'h00, "cb_frozen");
        wr(OFF_CTRL, 32'h1f);
        wr(OFF_WDOG, 32'hff);
        pulse(2);
        pulse(3);
        rd(OFF_CTRL, 32'h18, "pd_ctrl");
        rd(OFF_WDOG, 32'h00, "pd_wdog");
        settle();
        `CHK("alarm_pin", 1'b0, irq_oe_n)
        rd(OFF_FLAGS, 32'h40, "af_seen");
        settle();
        `CHK("alarm_pin_off", 1'b1, irq_oe_n)
        rd(OFF_FLAGS, 32'h00, "af_clear");
        wr(OFF_CLOCK, 32'h0f);
        wr(OFF_WDOG, 32'h5a);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, 32'h00, "rst_ctrl");
        rd(OFF_WDOG, 32'h00, "rst_wdog");
        rd(OFF_CLOCK, 32'h0f, "rst_clock");
        rd(16'h0100, 32'h00, "hole_data");
        `CHK("hole_err", 1'b1, e)
        summarize();
    end
    // run needs about 140 cycles; this bound only catches a hang
    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        summarize();
    end
endmodule // rbcd_top_tb_top
